// ==== hw/drc_pkg.sv ====
package drc_pkg;
  localparam int HIS_W = 3;
  localparam logic [2:0] HIS_RST = 3'h0;
  localparam int CLK_HZ = 40000000;
  localparam int INIT_WAIT_US = 100;
  localparam int INIT_WAIT_CYC = (CLK_HZ / 1000000) * INIT_WAIT_US;
  localparam int CNT_W = 13;
  localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam int SWRST_BIT = 7;
  localparam int TEN_BIT = 7;
  localparam int ELEVEN_BIT = 4;
  localparam logic [2:0] SYNC_INIT = 3'h7;

  typedef enum logic [1:0] {
    DRC_IN_RESET = 2'h0,
    DRC_WAIT = 2'h1,
    DRC_READY = 2'h3
  } drc_state_e;

  typedef struct packed {
    logic in_reset;
    logic init_wait;
    logic init_ok;
  } drc_stat_s;
endpackage : drc_pkg

// ==== hw/drc_top.sv ====
`timescale 1ns/1ps
// Functional notes
// - the active-low reset pin asynchronously resets all logic except the test-port logic, the pin and strap synchronisers and the stored strap.
// - while the reset pin is low every register it resets holds its default value; the synchronisers and stored strap keep running.
// - pin-strapped fields, host_interface_select among them, capture their pins at pin release.
// - the software reset bit resets everything except host interface, test port, itself, the pin and strap synchronisers and the stored strap.
// - a software reset never samples the strap pins again.
// - a software reset restores strapped fields to the values caught at the last pin release.
// - three independent reset controls exist: reset pin, software bit, test-port reset pin.
// - at reset pin release the three interface select pins are caught into interface_config_reg; while the pin is low it holds its default.
module drc_top (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic RST_N_PIN,
  input wire logic TEST_PORT_RESET_N,
  input wire logic TCK,
  input wire logic [2:0] HOST_INTERFACE_SELECT_PIN,
  input wire logic MC_ONE_WE,
  input wire logic [7:0] MC_ONE_WDATA,
  input wire logic MC_TEN_WE,
  input wire logic [7:0] MC_TEN_WDATA,
  input wire logic MC_ELEVEN_WE,
  input wire logic [7:0] MC_ELEVEN_WDATA,
  output logic [7:0] MASTER_CONTROL_ONE,
  output logic [7:0] MASTER_CONTROL_TEN,
  output logic [7:0] MASTER_CONTROL_ELEVEN,
  output logic [2:0] INTERFACE_CONFIG_REG,
  output logic CORE_RESET,
  output logic TEST_PORT_RESET,
  output logic [2:0] STATUS
);
  // reset pin through three flops; low counts once the last two agree
  logic [2:0] pin_sync_q;
  logic [2:0] pin_sync_d;
  logic pin_low_q;
  logic pin_low_d;
  logic pin_rel;
  always_comb begin
    pin_sync_d = {pin_sync_q[1:0], RST_N_PIN};
    pin_low_d = pin_low_q;
    if (pin_sync_q[1] == pin_sync_q[2]) begin
      pin_low_d = ~pin_sync_q[2];
    end
  end
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pin_sync_q <= drc_pkg::SYNC_INIT;
      pin_low_q <= 1'b0;
    end else begin
      pin_sync_q <= pin_sync_d;
      pin_low_q <= pin_low_d;
    end
  end
  assign pin_rel = pin_low_q & ~pin_low_d;
  wire logic hard_rst = RESET | ~RST_N_PIN;

  // strap pins synchronised, caught whenever the synchronised pin is low
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      s1_q <= drc_pkg::HIS_RST;
      s2_q <= drc_pkg::HIS_RST;
      s3_q <= drc_pkg::HIS_RST;
    end else begin
      s1_q <= HOST_INTERFACE_SELECT_PIN;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // a strap change counts once the second and third stages agree
  wire logic strap_agree = (s2_q == s3_q);
  logic [2:0] strap_q;
  logic [2:0] strap_d;
  always_comb begin
    strap_d = strap_q;
    if (pin_low_q & strap_agree) begin
      strap_d = s3_q;
    end
  end
  // stored strap is not cleared by the pin so its last caught value persists
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      strap_q <= drc_pkg::HIS_RST;
    end else begin
      strap_q <= strap_d;
    end
  end

  // software reset bit; host interface keeps it, cleared only by hard reset or a write
  logic [7:0] mc_one_q;
  logic [7:0] mc_one_d;
  always_comb begin
    mc_one_d = mc_one_q;
    if (MC_ONE_WE) begin
      mc_one_d = MC_ONE_WDATA;
    end
  end
  always_ff @(posedge CLK or posedge hard_rst) begin
    if (hard_rst) begin
      mc_one_q <= drc_pkg::MCR_RST;
    end else begin
      mc_one_q <= mc_one_d;
    end
  end
  wire logic sw_rst = mc_one_q[drc_pkg::SWRST_BIT];

  // core registers, reset by pin or software bit
  // writes are dropped without notice while either reset is active
  logic [7:0] mc_ten_q;
  logic [7:0] mc_ten_d;
  logic [7:0] mc_eleven_q;
  logic [7:0] mc_eleven_d;
  logic [2:0] icfg_q;
  logic [2:0] icfg_d;
  always_comb begin
    mc_ten_d = mc_ten_q;
    mc_eleven_d = mc_eleven_q;
    icfg_d = icfg_q;
    if (sw_rst) begin
      mc_ten_d = drc_pkg::MCR_RST;
      mc_eleven_d = drc_pkg::MCR_RST;
      icfg_d = strap_q;
    end else if (pin_rel | pin_low_q) begin
      if (strap_agree) begin
        icfg_d = s3_q;
      end
    end else begin
      if (MC_TEN_WE) begin
        mc_ten_d = MC_TEN_WDATA;
      end
      if (MC_ELEVEN_WE) begin
        mc_eleven_d = MC_ELEVEN_WDATA;
      end
    end
  end
  always_ff @(posedge CLK or posedge hard_rst) begin
    if (hard_rst) begin
      mc_ten_q <= drc_pkg::MCR_RST;
      mc_eleven_q <= drc_pkg::MCR_RST;
      icfg_q <= drc_pkg::HIS_RST;
    end else begin
      mc_ten_q <= mc_ten_d;
      mc_eleven_q <= mc_eleven_d;
      icfg_q <= icfg_d;
    end
  end

  // post-reset wait status for software
  drc_pkg::drc_state_e st_q;
  drc_pkg::drc_state_e st_d;
  logic [drc_pkg::CNT_W-1:0] cnt_q;
  logic [drc_pkg::CNT_W-1:0] cnt_d;
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      drc_pkg::DRC_IN_RESET: begin
        cnt_d = drc_pkg::CNT_W'(drc_pkg::INIT_WAIT_CYC);
        if (!sw_rst) begin
          st_d = drc_pkg::DRC_WAIT;
        end
      end
      drc_pkg::DRC_WAIT: begin
        cnt_d = cnt_q - drc_pkg::CNT_ONE;
        if (sw_rst) begin
          st_d = drc_pkg::DRC_IN_RESET;
        end else if (cnt_q == drc_pkg::CNT_ONE) begin
          st_d = drc_pkg::DRC_READY;
        end
      end
      default: begin
        if (sw_rst) begin
          st_d = drc_pkg::DRC_IN_RESET;
        end
      end
    endcase
  end
  always_ff @(posedge CLK or posedge hard_rst) begin
    if (hard_rst) begin
      st_q <= drc_pkg::DRC_IN_RESET;
      cnt_q <= drc_pkg::CNT_ZERO;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // test-port reset domain: only the test-port pin touches it
  logic tp_q;
  always_ff @(posedge TCK or negedge TEST_PORT_RESET_N) begin
    if (!TEST_PORT_RESET_N) begin
      tp_q <= 1'b1;
    end else begin
      tp_q <= 1'b0;
    end
  end

  drc_pkg::drc_stat_s stat;
  always_comb begin
    stat.in_reset = (st_q == drc_pkg::DRC_IN_RESET);
    stat.init_wait = (st_q == drc_pkg::DRC_WAIT);
    stat.init_ok = (st_q == drc_pkg::DRC_READY) & mc_ten_q[drc_pkg::TEN_BIT]
      & mc_eleven_q[drc_pkg::ELEVEN_BIT];
  end

  assign MASTER_CONTROL_ONE = mc_one_q;
  assign MASTER_CONTROL_TEN = mc_ten_q;
  assign MASTER_CONTROL_ELEVEN = mc_eleven_q;
  assign INTERFACE_CONFIG_REG = icfg_q;
  assign CORE_RESET = hard_rst | sw_rst;
  assign TEST_PORT_RESET = tp_q;
  assign STATUS = stat;
endmodule : drc_top

// ==== test/drc_properties.sv ====
`timescale 1ns/1ps
module drc_properties (
  input logic CLK,
  input logic RESET,
  input logic RST_N_PIN,
  input logic TEST_PORT_RESET_N,
  input logic [2:0] HOST_INTERFACE_SELECT_PIN,
  input logic MC_ONE_WE,
  input logic [7:0] MC_ONE_WDATA,
  input logic [7:0] MASTER_CONTROL_ONE,
  input logic [7:0] MASTER_CONTROL_TEN,
  input logic [7:0] MASTER_CONTROL_ELEVEN,
  input logic [2:0] INTERFACE_CONFIG_REG,
  input logic CORE_RESET,
  input logic TEST_PORT_RESET,
  input logic [2:0] STATUS
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  a_core_reset_eq: assert property (CORE_RESET == (!RST_N_PIN || MASTER_CONTROL_ONE[7]))
    else $error("core reset mismatch");
  a_pin_clears: assert property (!RST_N_PIN |-> {MASTER_CONTROL_ONE, MASTER_CONTROL_TEN} == 16'h0)
    else $error("register not cleared by pin");
  a_soft_clears: assert property (MASTER_CONTROL_ONE[7] |=> {MASTER_CONTROL_TEN, MASTER_CONTROL_ELEVEN} == 16'h0)
    else $error("register not cleared by soft reset");
  a_ctrl_one_keeps: assert property (RST_N_PIN[*4] ##0 MC_ONE_WE |=> !RST_N_PIN || MASTER_CONTROL_ONE == $past(MC_ONE_WDATA))
    else $error("control one lost its write");
  a_strap_capture: assert property (($stable(HOST_INTERFACE_SELECT_PIN) && !RST_N_PIN)[*6] ##1 (RST_N_PIN && $stable(HOST_INTERFACE_SELECT_PIN))[*4] |=> INTERFACE_CONFIG_REG == HOST_INTERFACE_SELECT_PIN)
    else $error("strap not captured");
  a_strap_hold: assert property (RST_N_PIN[*5] |=> !RST_N_PIN || $stable(INTERFACE_CONFIG_REG))
    else $error("strap field moved");
  a_test_reset: assert property (!TEST_PORT_RESET_N |-> TEST_PORT_RESET)
    else $error("test port reset missing");
  a_wait_flag: assert property ($fell(CORE_RESET) |-> ##5 STATUS[1] [*8])
    else $error("init wait flag missing");
  a_init_ok: assert property (STATUS[0] |-> MASTER_CONTROL_TEN[7] && MASTER_CONTROL_ELEVEN[4])
    else $error("init ok without tuning bits");
  c_soft: cover property (MASTER_CONTROL_ONE[7]);
  c_ok: cover property (STATUS[0]);
  c_cap: cover property ($rose(RST_N_PIN));
endmodule : drc_properties
bind drc_top drc_properties u_props (.*);

// ==== test/drc_board_model.sv ====
`timescale 1ns/1ps
module drc_board_model (
  input logic CLK,
  output logic RST_N_PIN,
  output logic MC_TEN_WE,
  output logic [7:0] MC_TEN_WDATA,
  output logic MC_ELEVEN_WE,
  output logic [7:0] MC_ELEVEN_WDATA
);
  initial begin
    RST_N_PIN = 1'b0;
    MC_TEN_WE = 1'b0;
    MC_ELEVEN_WE = 1'b0;
    MC_TEN_WDATA = 8'h00;
    MC_ELEVEN_WDATA = 8'h00;
  end
  task automatic pulse(input int n);
    @(posedge CLK);
    RST_N_PIN <= 1'b0;
    repeat (n) @(posedge CLK);
    RST_N_PIN <= 1'b1;
  endtask : pulse
  task automatic wr(input logic eleven, input logic [7:0] d);
    @(posedge CLK);
    MC_TEN_WE <= !eleven;
    MC_ELEVEN_WE <= eleven;
    MC_TEN_WDATA <= d;
    MC_ELEVEN_WDATA <= d;
    @(posedge CLK);
    MC_TEN_WE <= 1'b0;
    MC_ELEVEN_WE <= 1'b0;
    MC_TEN_WDATA <= ~d;
    MC_ELEVEN_WDATA <= ~d;
  endtask : wr
  task automatic init_script();
    repeat (drc_pkg::INIT_WAIT_CYC) @(posedge CLK);
    wr(1'b0, 8'h80);
    wr(1'b1, 8'h10);
  endtask : init_script
endmodule : drc_board_model

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic TEST_PORT_RESET_N = 1'b1;
  logic TCK = 1'b0;
  logic [2:0] HOST_INTERFACE_SELECT_PIN = 3'h5;
  logic MC_ONE_WE = 1'b0;
  logic [7:0] MC_ONE_WDATA = 8'h00;
  logic RST_N_PIN, MC_TEN_WE, MC_ELEVEN_WE, CORE_RESET, TEST_PORT_RESET;
  logic [7:0] MC_TEN_WDATA, MC_ELEVEN_WDATA;
  logic [7:0] MASTER_CONTROL_ONE, MASTER_CONTROL_TEN, MASTER_CONTROL_ELEVEN;
  logic [2:0] INTERFACE_CONFIG_REG, STATUS;
  int n_fail = 0;
  int tests_run = 0;
  always #12.5 CLK = ~CLK;
  drc_board_model board (.*);
  drc_top dut (.*);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr1(input logic [7:0] d);
    @(posedge CLK);
    MC_ONE_WE <= 1'b1;
    MC_ONE_WDATA <= d;
    @(posedge CLK);
    MC_ONE_WE <= 1'b0;
    @(negedge CLK);
  endtask : wr1
  task automatic t_power();
    board.pulse(8);
    repeat (6) @(negedge CLK);
    check({5'h0, INTERFACE_CONFIG_REG}, 8'h05);
    check(MASTER_CONTROL_ONE | MASTER_CONTROL_TEN, 8'h00);
    check({5'h0, STATUS}, 8'h02);
    board.init_script();
    @(negedge CLK);
    check({5'h0, STATUS}, 8'h01);
    check(MASTER_CONTROL_TEN, 8'h80);
    $display("t_power done");
  endtask : t_power
  task automatic t_test();
    @(posedge CLK);
    TEST_PORT_RESET_N <= 1'b0;
    @(negedge CLK);
    check({7'h0, TEST_PORT_RESET}, 8'h01);
    check(MASTER_CONTROL_ELEVEN, 8'h10);
    @(posedge CLK);
    TEST_PORT_RESET_N <= 1'b1;
    @(posedge CLK);
    TCK <= 1'b1;
    @(negedge CLK);
    check({7'h0, TEST_PORT_RESET}, 8'h00);
    @(posedge CLK);
    TCK <= 1'b0;
    $display("t_test done");
  endtask : t_test
  task automatic t_soft();
    @(posedge CLK);
    HOST_INTERFACE_SELECT_PIN <= 3'h2;
    wr1(8'h80);
    check({7'h0, CORE_RESET}, 8'h01);
    board.wr(1'b0, 8'h80);
    @(negedge CLK);
    check(MASTER_CONTROL_TEN | MASTER_CONTROL_ELEVEN, 8'h00);
    check({5'h0, INTERFACE_CONFIG_REG}, 8'h05);
    check(MASTER_CONTROL_ONE, 8'h80);
    wr1(8'h01);
    check({7'h0, CORE_RESET}, 8'h00);
    $display("t_soft done");
  endtask : t_soft
  task automatic t_pin();
    repeat (16) @(posedge CLK);
    fork
      board.pulse(8);
      begin
        repeat (3) @(negedge CLK);
        check(MASTER_CONTROL_ONE, 8'h00);
        check({6'h0, CORE_RESET, TEST_PORT_RESET}, 8'h02);
      end
    join
    repeat (12) @(negedge CLK);
    check({5'h0, INTERFACE_CONFIG_REG}, 8'h02);
    $display("t_pin done");
  endtask : t_pin
  task automatic finish_test();
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (10) @(posedge CLK);
    RESET <= 1'b0;
    t_power();
    t_test();
    t_soft();
    t_pin();
    finish_test();
  end
endmodule : tb_top
